// ### rtl/sgc_top.sv
// Purpose: Supply guard, periodic wake-up timer and external pin request control
// Assumes: Detector levels and pin are asynchronous; sys_rst_i is the power-up reset
// Notes: Other reset kinds arrive as a synchronous pulse on other_rst_i with no cause code
`timescale 1ns/1ns
`default_nettype none
module sgc_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Other reset kinds: one-cycle pulse
  input wire logic other_rst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // CPU status
  input wire logic halt_exec_i,
  input wire logic [1:0] halt_kind_i,
  input wire logic wake_i,
  // Analog detectors and clocks
  input wire logic below_detect_i,
  input wire logic below_warn_i,
  input wire logic below_rearm_i,
  input wire logic ext_tick_i,
  input wire logic int_tick_i,
  // External pin
  input wire logic pin_i,
  // Outputs
  output logic pin_pull_en_o,
  output logic pin_pull_down_o,
  output logic pin_irq_o,
  output logic low_supply_irq_o,
  output logic periodic_irq_o,
  output logic wake_o,
  output logic sys_reset_o,
  output logic guarded_o,
  output logic [2:0] mode_o
);
  sgc_pkg::sgc_bus_t bus;
  sgc_pkg::sgc_supply_t sup;
  sgc_pkg::sgc_mode_t mode;
  sgc_pkg::sgc_mode_t next_mode;
  logic pin_s;
  logic pin_prev;
  logic ext_s;
  logic ext_prev;
  logic int_s;
  logic int_prev;
  logic det_s;
  logic warn_s;
  logic rearm_s;
  // Registers
  logic pin_pol;
  logic pin_fen;
  logic pin_flag;
  logic pin_ien;
  logic pin_mode;
  logic low_supply_reset_enable;
  logic rst_en_written;
  logic low_supply_irq_enable;
  logic low_supply_flag;
  logic guard_bit;
  logic osc_halt_en;
  logic osc_range;
  logic tmr_flag;
  logic tmr_ien;
  logic tmr_src_int;
  logic [2:0] period_sel;
  logic cause_pwrup;
  logic cause_low;
  logic low_hold;
  logic guarded;
  logic [sgc_pkg::TICK_W-1:0] base_cnt;
  logic [15:0] period_cnt;
  // Decodes
  assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign sup = '{below_detect: det_s, below_warn: warn_s, below_rearm: rearm_s};
  wire wr_pin = bus.wr && (bus.addr == sgc_pkg::OFF_PIN_CTRL);
  wire wr_pwr1 = bus.wr && (bus.addr == sgc_pkg::OFF_PWR_ONE);
  wire wr_pwr2 = bus.wr && (bus.addr == sgc_pkg::OFF_PWR_TWO);
  wire wr_tmr = bus.wr && (bus.addr == sgc_pkg::OFF_TIMER_CTRL);
  // Guard bit only matters in interrupt configuration; it blocks requests only while below re-arm
  wire guard_eff = guard_bit && !low_supply_reset_enable;
  wire block_all = guard_eff && sup.below_rearm;
  // Pin detection
  wire pin_asserted = pin_fen && (pin_pol ? pin_s : !pin_s);
  wire prev_asserted = pin_pol ? pin_prev : !pin_prev;
  wire pin_edge = pin_fen && pin_asserted && !prev_asserted;
  wire pin_level = pin_mode && pin_asserted;
  wire pin_ack = wr_pin && bus.wdata[sgc_pkg::PIN_ACK_BIT];
  // Set wins over acknowledge; level mode re-sets while asserted
  wire next_pin_flag = pin_edge || pin_level || (pin_flag && !pin_ack);
  // Low-supply detection
  wire low_ack = wr_pwr1 && bus.wdata[sgc_pkg::PWR1_ACK_BIT];
  wire next_low_flag = sup.below_detect || (low_supply_flag && !low_ack);
  wire low_reset_req = sup.below_detect && low_supply_reset_enable && !block_all;
  // Periodic timer clock choice by mode
  wire use_int = (mode == sgc_pkg::SGC_DEEP) ||
                 ((mode == sgc_pkg::SGC_PART) && tmr_src_int);
  wire tmr_run = (period_sel != 3'h0) && (mode != sgc_pkg::SGC_FULL);
  wire src_edge = use_int ? (int_s && !int_prev) : (ext_s && !ext_prev);
  wire [15:0] period_len = 16'h0001 << (5'd3 * {2'b00, period_sel});
  wire tmr_done = tmr_run && src_edge && (period_cnt + 16'h0001 >= period_len);
  wire tmr_ack = wr_tmr && bus.wdata[sgc_pkg::TMR_ACK_BIT];
  wire next_tmr_flag = tmr_done || (tmr_flag && !tmr_ack);
  // Mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      sgc_pkg::SGC_RUN: begin
        if (halt_exec_i) begin
          case (halt_kind_i)
            sgc_pkg::HALT_FULL: next_mode = sgc_pkg::SGC_FULL;
            sgc_pkg::HALT_DEEP: next_mode = sgc_pkg::SGC_DEEP;
            sgc_pkg::HALT_PART: next_mode = sgc_pkg::SGC_PART;
            default: next_mode = sgc_pkg::SGC_WAIT;
          endcase
        end
      end
      sgc_pkg::SGC_WAIT, sgc_pkg::SGC_PART, sgc_pkg::SGC_DEEP, sgc_pkg::SGC_FULL: begin
        if (wake_o) begin
          next_mode = sgc_pkg::SGC_RUN;
        end
      end
      default: next_mode = sgc_pkg::SGC_RUN;
    endcase
  end
  // Synchronisers
  sgc_sync3 u_sync_pin (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(pin_i), .sync_o(pin_s));
  sgc_sync3 u_sync_ext (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(ext_tick_i), .sync_o(ext_s));
  sgc_sync3 u_sync_int (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(int_tick_i), .sync_o(int_s));
  sgc_sync3 u_sync_det (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(below_detect_i), .sync_o(det_s));
  sgc_sync3 u_sync_wrn (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(below_warn_i), .sync_o(warn_s));
  sgc_sync3 u_sync_rea (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(below_rearm_i), .sync_o(rearm_s));
  // Pin register and detector
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {pin_pol, pin_fen, pin_ien, pin_mode} <= 4'h0;
      pin_flag <= 1'b0;
      pin_prev <= 1'b0;
    end else if (sys_reset_o) begin
      {pin_pol, pin_fen, pin_ien, pin_mode} <= 4'h0;
      pin_flag <= 1'b0;
      pin_prev <= pin_s;
    end else begin
      pin_prev <= pin_s;
      pin_flag <= next_pin_flag;
      if (wr_pin) begin
        pin_pol <= bus.wdata[sgc_pkg::PIN_POL_BIT];
        pin_fen <= bus.wdata[sgc_pkg::PIN_FEN_BIT];
        pin_ien <= bus.wdata[sgc_pkg::PIN_IEN_BIT];
        pin_mode <= bus.wdata[sgc_pkg::PIN_MODE_BIT];
      end
    end
  end
  // Supply guard registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_supply_reset_enable <= 1'b1;
      rst_en_written <= 1'b0;
      low_supply_irq_enable <= 1'b0;
      low_supply_flag <= 1'b0;
      guard_bit <= 1'b0;
      osc_halt_en <= 1'b0;
      osc_range <= 1'b0;
      cause_pwrup <= 1'b1;
      cause_low <= 1'b1;
      low_hold <= 1'b0;
      guarded <= 1'b0;
    end else begin
      // Hold reset until the detector reports recovery
      if (low_reset_req) begin
        low_hold <= 1'b1;
        cause_pwrup <= 1'b0;
        cause_low <= 1'b1;
      end else if (!sup.below_detect) begin
        low_hold <= 1'b0;
      end
      if (other_rst_i && !block_all) begin
        cause_pwrup <= 1'b0;
        cause_low <= 1'b0;
      end
      if (sys_reset_o) begin
        // Reset enable survives non power-up resets
        rst_en_written <= 1'b0;
        low_supply_irq_enable <= 1'b0;
        low_supply_flag <= 1'b0;
        guard_bit <= 1'b0;
        guarded <= 1'b0;
      end else begin
        low_supply_flag <= next_low_flag;
        if (wr_pwr1) begin
          low_supply_irq_enable <= bus.wdata[sgc_pkg::PWR1_IEN_BIT];
          guard_bit <= bus.wdata[sgc_pkg::PWR1_GUARD_BIT];
          if (!rst_en_written) begin
            low_supply_reset_enable <= bus.wdata[sgc_pkg::PWR1_RST_EN_BIT];
            rst_en_written <= 1'b1;
          end
        end
        if (wr_pwr2) begin
          osc_halt_en <= bus.wdata[sgc_pkg::PWR2_OSC_HALT_BIT];
          osc_range <= bus.wdata[sgc_pkg::PWR2_RANGE_BIT];
        end
        if (halt_exec_i && (mode == sgc_pkg::SGC_RUN) && guard_eff && low_supply_flag) begin
          guarded <= 1'b1;
        end else if (wake_o) begin
          guarded <= 1'b0;
        end
      end
    end
  end
  // Periodic timer
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {tmr_ien, tmr_src_int, tmr_flag} <= 3'h0;
      period_sel <= sgc_pkg::PERIOD_RST;
      period_cnt <= 16'h0000;
      ext_prev <= 1'b0;
      int_prev <= 1'b0;
      mode <= sgc_pkg::SGC_RUN;
    end else if (sys_reset_o) begin
      {tmr_ien, tmr_src_int, tmr_flag} <= 3'h0;
      period_sel <= sgc_pkg::PERIOD_RST;
      period_cnt <= 16'h0000;
      mode <= sgc_pkg::SGC_RUN;
    end else begin
      ext_prev <= ext_s;
      int_prev <= int_s;
      mode <= next_mode;
      tmr_flag <= next_tmr_flag;
      if (!tmr_run || tmr_done) begin
        period_cnt <= 16'h0000;
      end else if (src_edge) begin
        period_cnt <= period_cnt + 16'h0001;
      end
      if (wr_tmr) begin
        tmr_src_int <= bus.wdata[sgc_pkg::TMR_SRC_BIT];
        tmr_ien <= bus.wdata[sgc_pkg::TMR_IEN_BIT];
        period_sel <= bus.wdata[2:0];
      end
    end
  end
  // Register reads, one cycle after the strobe
  wire [7:0] rd_pin = {2'b00, pin_pol, pin_fen, pin_flag, 1'b0, pin_ien, pin_mode};
  wire [7:0] rd_pwr1 = {low_supply_flag, 1'b0, low_supply_irq_enable, low_supply_reset_enable,
                        guard_bit, 3'h0};
  wire [7:0] rd_pwr2 = {sup.below_warn, 5'h00, osc_halt_en, osc_range};
  wire [7:0] rd_tmr = {tmr_flag, 1'b0, tmr_src_int, tmr_ien, 1'b0, period_sel};
  wire [7:0] rd_cause = {cause_pwrup, 5'h00, cause_low, 1'b0};
  wire [7:0] rd_mux = (bus.addr == sgc_pkg::OFF_PIN_CTRL) ? rd_pin :
                      (bus.addr == sgc_pkg::OFF_PWR_ONE) ? rd_pwr1 :
                      (bus.addr == sgc_pkg::OFF_PWR_TWO) ? rd_pwr2 :
                      (bus.addr == sgc_pkg::OFF_TIMER_CTRL) ? rd_tmr :
                      (bus.addr == sgc_pkg::OFF_RESET_CAUSE) ? rd_cause : 8'h00;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= bus.rd ? rd_mux : 8'h00;
    end
  end
  // Outputs: every request is gated by the guarded block
  assign pin_pull_en_o = pin_fen;
  assign pin_pull_down_o = pin_fen && pin_pol;
  assign pin_irq_o = pin_ien && pin_flag && !block_all;
  assign low_supply_irq_o = low_supply_flag && low_supply_irq_enable &&
                            !low_supply_reset_enable && !block_all;
  assign periodic_irq_o = tmr_flag && tmr_ien && !block_all;
  assign wake_o = (mode != sgc_pkg::SGC_RUN) && !block_all &&
                  (wake_i || pin_irq_o || periodic_irq_o || low_supply_irq_o);
  assign sys_reset_o = low_hold || (other_rst_i && !block_all);
  assign guarded_o = guarded;
  assign mode_o = mode;
endmodule
`default_nettype wire

// ### shared/sgc_pkg.sv
// Purpose: Shared constants and types for the supply guard / periodic timer / pin request block
// Assumes: 8-bit register port, one clock at 125 MHz
// Notes: Register offsets are local to this block
package sgc_pkg;
  // Register offsets
  localparam logic [2:0] OFF_PIN_CTRL = 3'h0;
  localparam logic [2:0] OFF_PWR_ONE = 3'h1;
  localparam logic [2:0] OFF_PWR_TWO = 3'h2;
  localparam logic [2:0] OFF_TIMER_CTRL = 3'h3;
  localparam logic [2:0] OFF_RESET_CAUSE = 3'h4;
  localparam logic [2:0] OFF_HALT_CMD = 3'h5;
  // Pin request register fields
  localparam int PIN_POL_BIT = 5;
  localparam int PIN_FEN_BIT = 4;
  localparam int PIN_FLAG_BIT = 3;
  localparam int PIN_ACK_BIT = 2;
  localparam int PIN_IEN_BIT = 1;
  localparam int PIN_MODE_BIT = 0;
  // Power control one fields
  localparam int PWR1_FLAG_BIT = 7;
  localparam int PWR1_ACK_BIT = 6;
  localparam int PWR1_IEN_BIT = 5;
  localparam int PWR1_RST_EN_BIT = 4;
  localparam int PWR1_GUARD_BIT = 3;
  // Power control two fields
  localparam int PWR2_WARN_BIT = 7;
  localparam int PWR2_OSC_HALT_BIT = 1;
  localparam int PWR2_RANGE_BIT = 0;
  // Timer control fields
  localparam int TMR_FLAG_BIT = 7;
  localparam int TMR_ACK_BIT = 6;
  localparam int TMR_SRC_BIT = 5;
  localparam int TMR_IEN_BIT = 4;
  // Reset cause fields
  localparam int CAUSE_PWRUP_BIT = 7;
  localparam int CAUSE_LOW_BIT = 1;
  // Halt command codes
  localparam logic [1:0] HALT_FULL = 2'h1;
  localparam logic [1:0] HALT_DEEP = 2'h2;
  localparam logic [1:0] HALT_PART = 2'h3;
  // Reset values
  localparam logic [7:0] PIN_CTRL_RST = 8'h00;
  localparam logic [2:0] PERIOD_RST = 3'h0;
  // Time base: divider counts per period step
  localparam int CLK_MHZ = 125;
  localparam int BASE_TICK_US = 1;
  localparam int BASE_TICK_CYC = BASE_TICK_US * CLK_MHZ;
  localparam int TICK_W = 16;
  // Operating modes, Gray along run -> wait -> halts
  typedef enum logic [2:0] {
    SGC_RUN = 3'b000,
    SGC_WAIT = 3'b001,
    SGC_PART = 3'b011,
    SGC_DEEP = 3'b010,
    SGC_FULL = 3'b110
  } sgc_mode_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sgc_bus_t;
  typedef struct packed {
    logic below_detect;
    logic below_warn;
    logic below_rearm;
  } sgc_supply_t;
endpackage

// ### rtl/sgc_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to mclk_i
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module sgc_sync3 (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Data
  input wire logic async_i,
  output logic sync_o
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_o <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/sgc_top_assertions.sv
// Purpose: Port-level checks for sgc_top
// Assumes: One clock, sys_rst_i asynchronous active high
// Notes: Register reads tie the combinational outputs back to register state
`timescale 1ns/1ns
`default_nettype none
module sgc_checker (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Watched outputs
  input wire logic pin_pull_en_o,
  input wire logic pin_pull_down_o,
  input wire logic pin_irq_o,
  input wire logic low_supply_irq_o,
  input wire logic periodic_irq_o,
  input wire logic [2:0] mode_o
);
  wire rd_pin = reg_rd_i && (reg_addr_i == sgc_pkg::OFF_PIN_CTRL);
  wire rd_pwr = reg_rd_i && (reg_addr_i == sgc_pkg::OFF_PWR_ONE);
  wire rd_tmr = reg_rd_i && (reg_addr_i == sgc_pkg::OFF_TIMER_CTRL);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_pin_ack_zero: assert property ($past(rd_pin) |-> reg_rdata_o[7:6] == 2'h0 && !reg_rdata_o[2])
    else $error("pin register ack or spare bits read nonzero");
  a_pin_irq_flag: assert property ($past(rd_pin) |-> (reg_rdata_o[3] & reg_rdata_o[1]) == $past(pin_irq_o))
    else $error("pin interrupt differs from flag and enable");
  a_pull_enable: assert property ($past(rd_pin) |-> reg_rdata_o[4] == $past(pin_pull_en_o))
    else $error("pull enable differs from function enable");
  a_pull_dir: assert property ($past(rd_pin && pin_pull_en_o) |-> reg_rdata_o[5] == $past(pin_pull_down_o))
    else $error("pull direction differs from polarity");
  a_low_irq_gate: assert property ($past(rd_pwr) && reg_rdata_o[4] |-> !$past(low_supply_irq_o))
    else $error("low supply interrupt while reset enable set");
  a_tmr_ack_zero: assert property ($past(rd_tmr) |-> !reg_rdata_o[6])
    else $error("timer ack bit read nonzero");
  a_tmr_irq_flag: assert property ($past(rd_tmr) && !(reg_rdata_o[7] && reg_rdata_o[4]) |-> !$past(periodic_irq_o))
    else $error("periodic interrupt without flag and enable");
  a_full_no_tick: assert property (mode_o == sgc_pkg::SGC_FULL && !periodic_irq_o && !reg_wr_i |=> !periodic_irq_o)
    else $error("periodic interrupt raised in full halt");
  c_pin_irq: cover property ($rose(pin_irq_o));
  c_low_irq: cover property ($rose(low_supply_irq_o));
  c_tmr_irq: cover property ($rose(periodic_irq_o));
endmodule
bind sgc_top sgc_checker u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pin_pull_en_o(pin_pull_en_o),
  .pin_pull_down_o(pin_pull_down_o), .pin_irq_o(pin_irq_o), .low_supply_irq_o(low_supply_irq_o),
  .periodic_irq_o(periodic_irq_o), .mode_o(mode_o));
`default_nettype wire

// ### bench/sgc_partner.sv
// Purpose: Far side: external pin source, supply detectors, source clocks
// Assumes: Levels change only when the bench calls the tasks
// Notes: Clock periods are unrelated to mclk_i so sampling phase drifts
`timescale 1ns/1ns
`default_nettype none
module sgc_partner (
  // Pin and supply levels
  output var logic pin_o,
  output var sgc_pkg::sgc_supply_t sup_o,
  // Free-running source clocks
  output var logic ext_tick_o,
  output var logic int_tick_o
);
  initial begin
    pin_o = 1'b0;
    sup_o = '0;
    ext_tick_o = 1'b0;
    int_tick_o = 1'b0;
  end
  always #21 ext_tick_o = ~ext_tick_o;
  always #53 int_tick_o = ~int_tick_o;
  task set_pin(input logic v);
    pin_o = v;
  endtask
  task set_sup(input logic det, input logic warn, input logic rearm);
    sup_o = {det, warn, rearm};
  endtask
endmodule
`default_nettype wire

// ### bench/sgc_top_test.sv
// Purpose: Self-checking bench for sgc_top
// Assumes: Register port with read data one cycle after the strobe
// Notes: Pin and detector changes need a few cycles through the synchronisers
`timescale 1ns/1ns
`default_nettype none
module sgc_top_test;
  logic mclk_i, sys_rst_i, other_rst_i, reg_wr_i, reg_rd_i, halt_exec_i, wake_i;
  logic [2:0] reg_addr_i, mode_o;
  logic [7:0] reg_wdata_i, reg_rdata_o, v;
  logic [1:0] halt_kind_i;
  logic pin_i, ext_tick_i, int_tick_i, pin_pull_en_o, pin_pull_down_o, pin_irq_o;
  logic low_supply_irq_o, periodic_irq_o, wake_o, sys_reset_o, guarded_o;
  sgc_pkg::sgc_supply_t sup;
  int err_total = 0;
  int comparisons = 0;
  always #4 mclk_i = ~mclk_i;
  sgc_partner u_far (.pin_o(pin_i), .sup_o(sup), .ext_tick_o(ext_tick_i), .int_tick_o(int_tick_i));
  sgc_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .other_rst_i(other_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .halt_exec_i(halt_exec_i), .halt_kind_i(halt_kind_i), .wake_i(wake_i), .below_detect_i(sup.below_detect),
    .below_warn_i(sup.below_warn), .below_rearm_i(sup.below_rearm), .ext_tick_i(ext_tick_i),
    .int_tick_i(int_tick_i), .pin_i(pin_i), .pin_pull_en_o(pin_pull_en_o), .pin_pull_down_o(pin_pull_down_o),
    .pin_irq_o(pin_irq_o), .low_supply_irq_o(low_supply_irq_o), .periodic_irq_o(periodic_irq_o),
    .wake_o(wake_o), .sys_reset_o(sys_reset_o), .guarded_o(guarded_o), .mode_o(mode_o));
  task report_and_stop;
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bchk(input logic seen, input logic exp);
    chk({7'h0, seen}, {7'h0, exp});
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
    chk(v & m, e);
  endtask
  task halt(input logic [1:0] k);
    @(posedge mclk_i);
    halt_kind_i <= k;
    halt_exec_i <= 1'b1;
    @(posedge mclk_i);
    halt_exec_i <= 1'b0;
  endtask
  task pulse_rst(input logic e);
    @(posedge mclk_i);
    other_rst_i <= 1'b1;
    #1 bchk(sys_reset_o, e);
    @(posedge mclk_i);
    other_rst_i <= 1'b0;
  endtask
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
  initial begin
    mclk_i = 1'b0;
    sys_rst_i = 1'b1;
    {other_rst_i, reg_wr_i, reg_rd_i, halt_exec_i, wake_i} = '0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    halt_kind_i = 2'h0;
    wt(6);
    sys_rst_i <= 1'b0;
    rchk(sgc_pkg::OFF_RESET_CAUSE, 8'h82, 8'h82);
    rchk(sgc_pkg::OFF_PWR_ONE, 8'h10, 8'h10);
    rchk(3'h7, 8'hff, 8'h00);
    wr(3'h7, 8'hff);
    u_far.set_sup(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 20 && sys_reset_o !== 1'b1; i++) @(posedge mclk_i);
    wt(30);
    bchk(sys_reset_o, 1'b1);
    u_far.set_sup(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 20 && sys_reset_o !== 1'b0; i++) @(posedge mclk_i);
    wt(2);
    rchk(sgc_pkg::OFF_RESET_CAUSE, 8'h02, 8'h02);
    // Reset enable is write-once: the second write must not set it again
    wr(sgc_pkg::OFF_PWR_ONE, 8'h20);
    wr(sgc_pkg::OFF_PWR_ONE, 8'h30);
    rchk(sgc_pkg::OFF_PWR_ONE, 8'h30, 8'h20);
    u_far.set_sup(1'b0, 1'b1, 1'b0);
    wt(10);
    rchk(sgc_pkg::OFF_PWR_TWO, 8'h80, 8'h80);
    bchk(low_supply_irq_o, 1'b0);
    u_far.set_sup(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 20 && low_supply_irq_o !== 1'b1; i++) @(posedge mclk_i);
    bchk(low_supply_irq_o, 1'b1);
    rchk(sgc_pkg::OFF_PWR_ONE, 8'h80, 8'h80);
    u_far.set_sup(1'b0, 1'b0, 1'b0);
    wt(10);
    wr(sgc_pkg::OFF_PWR_ONE, 8'h60);
    wt(2);
    bchk(low_supply_irq_o, 1'b0);
    rchk(sgc_pkg::OFF_PWR_TWO, 8'h80, 8'h00);
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h32);
    wt(1);
    chk({6'h0, pin_pull_en_o, pin_pull_down_o}, 8'h03);
    u_far.set_pin(1'b1);
    for (int i = 0; i < 20 && pin_irq_o !== 1'b1; i++) @(posedge mclk_i);
    bchk(pin_irq_o, 1'b1);
    rchk(sgc_pkg::OFF_PIN_CTRL, 8'hff, 8'h3a);
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h36);
    rchk(sgc_pkg::OFF_PIN_CTRL, 8'hff, 8'h32);
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h33);
    wt(3);
    rchk(sgc_pkg::OFF_PIN_CTRL, 8'hff, 8'h3b);
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h37);
    rchk(sgc_pkg::OFF_PIN_CTRL, 8'hff, 8'h3b);
    u_far.set_pin(1'b0);
    wt(10);
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h37);
    rchk(sgc_pkg::OFF_PIN_CTRL, 8'hff, 8'h33);
    // Ack right after the polarity change in case it looked like an edge
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h12);
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h16);
    rchk(sgc_pkg::OFF_PIN_CTRL, 8'hff, 8'h12);
    chk({6'h0, pin_pull_en_o, pin_pull_down_o}, 8'h02);
    u_far.set_pin(1'b1);
    wt(10);
    u_far.set_pin(1'b0);
    for (int i = 0; i < 20 && pin_irq_o !== 1'b1; i++) @(posedge mclk_i);
    bchk(pin_irq_o, 1'b1);
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h10);
    wt(1);
    bchk(pin_irq_o, 1'b0);
    rchk(sgc_pkg::OFF_PIN_CTRL, 8'hff, 8'h18);
    wr(sgc_pkg::OFF_PIN_CTRL, 8'h00);
    wt(1);
    bchk(pin_pull_en_o, 1'b0);
    wr(sgc_pkg::OFF_PWR_ONE, 8'h28);
    u_far.set_sup(1'b1, 1'b1, 1'b1);
    wt(10);
    halt(sgc_pkg::HALT_DEEP);
    for (int i = 0; i < 20 && guarded_o !== 1'b1; i++) @(posedge mclk_i);
    bchk(guarded_o, 1'b1);
    wake_i <= 1'b1;
    pulse_rst(1'b0);
    bchk(wake_o, 1'b0);
    wake_i <= 1'b0;
    u_far.set_sup(1'b0, 1'b0, 1'b0);
    wt(10);
    rchk(sgc_pkg::OFF_PWR_ONE, 8'h08, 8'h08);
    // The sticky low-supply interrupt wakes the part as soon as the block lifts
    chk({5'h0, mode_o}, {5'h0, sgc_pkg::SGC_RUN});
    bchk(guarded_o, 1'b0);
    wake_i <= 1'b1;
    wt(4);
    wake_i <= 1'b0;
    wr(sgc_pkg::OFF_PWR_ONE, 8'h20);
    pulse_rst(1'b1);
    wt(2);
    rchk(sgc_pkg::OFF_PWR_ONE, 8'h18, 8'h00);
    wr(sgc_pkg::OFF_PWR_TWO, 8'h02);
    rchk(sgc_pkg::OFF_PWR_TWO, 8'h03, 8'h02);
    wr(sgc_pkg::OFF_TIMER_CTRL, 8'h11);
    for (int i = 0; i < 400 && periodic_irq_o !== 1'b1; i++) @(posedge mclk_i);
    bchk(periodic_irq_o, 1'b1);
    rchk(sgc_pkg::OFF_TIMER_CTRL, 8'hff, 8'h91);
    wr(sgc_pkg::OFF_TIMER_CTRL, 8'h50);
    wt(300);
    bchk(periodic_irq_o, 1'b0);
    rchk(sgc_pkg::OFF_TIMER_CTRL, 8'hff, 8'h10);
    // Halt right after a period ends so no tick lands before the halt
    wr(sgc_pkg::OFF_TIMER_CTRL, 8'h11);
    for (int i = 0; i < 400 && periodic_irq_o !== 1'b1; i++) @(posedge mclk_i);
    wr(sgc_pkg::OFF_TIMER_CTRL, 8'h51);
    halt(sgc_pkg::HALT_FULL);
    wt(3);
    chk({5'h0, mode_o}, {5'h0, sgc_pkg::SGC_FULL});
    wt(300);
    bchk(periodic_irq_o, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
